/* scge_pkg.sv */
/*
  Constants shared by the sleep clock gate enable block: register offsets,
  field positions, reset values, bus answers and the power mode encoding.
  Assumes the interconnect strips the system control base address, so only
  the low twelve address bits reach the block.
*/
package scge_pkg;

  // ==========================================================================
  // Address map
  // ==========================================================================
  localparam logic [31:0] SCGE_SYSCTL_BASE   = 32'h400F_E000;
  localparam int unsigned SCGE_ADDR_W        = 12;
  localparam logic [11:0] SCGE_OFS_RUN_CFG   = 12'h060;
  localparam logic [11:0] SCGE_OFS_RUN_GATE  = 12'h104;
  localparam logic [11:0] SCGE_OFS_SLEEP_GATE = 12'h114;
  localparam logic [11:0] SCGE_OFS_DEEP_GATE = 12'h124;
  localparam logic [11:0] SCGE_WORD_MASK     = 12'hFFC;

  // ==========================================================================
  // Gate register fields
  // ==========================================================================
  localparam int unsigned SCGE_BIT_ASYNC0 = 0;
  localparam int unsigned SCGE_BIT_ASYNC1 = 1;
  localparam int unsigned SCGE_BIT_ASYNC2 = 2;
  localparam int unsigned SCGE_BIT_SYNC0  = 4;
  localparam int unsigned SCGE_BIT_TWOW0  = 12;
  localparam int unsigned SCGE_BIT_GPC0   = 16;
  localparam int unsigned SCGE_BIT_GPC3   = 19;
  localparam int unsigned SCGE_BIT_CMP0   = 24;
  localparam int unsigned SCGE_BIT_CMP2   = 26;
  localparam logic [31:0] SCGE_GATE_MASK  = 32'h070F_1017;
  localparam logic [31:0] SCGE_GATE_RESET = 32'h0000_0000;

  // ==========================================================================
  // Run clock configuration fields
  // ==========================================================================
  localparam int unsigned SCGE_BIT_AUTO_GATE = 27;
  localparam logic [31:0] SCGE_CFG_MASK      = 32'h0800_0000;
  localparam logic [31:0] SCGE_CFG_RESET     = 32'h0000_0000;

  // ==========================================================================
  // Bus answers
  // ==========================================================================
  localparam logic [1:0]  SCGE_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  SCGE_RESP_SLVERR = 2'h2;
  localparam logic [31:0] SCGE_RDATA_NONE  = 32'h0000_0000;

  // ==========================================================================
  // Applied power mode
  // ==========================================================================
  typedef enum logic [2:0] {
    SCGE_PM_RUN   = 3'h1,
    SCGE_PM_SLEEP = 3'h2,
    SCGE_PM_DEEP  = 3'h4
  } scge_pmode_t;

endpackage

/* scge_fault.sv */
/*
  Access checker for the gated peripheral units: answers each access
  request one cycle later with done, plus fault when the unit is unclocked.
  Assumes requests are synchronous to aclk and the enables come from flops.
*/
module scge_fault (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Applied clock enables
  input  wire logic [31:0] clk_en,
  // Access request and answer
  input  wire logic        access_req,
  input  wire logic [4:0]  access_unit,
  output logic             access_done,
  output logic             access_fault
);

  typedef struct packed {
    logic done;
    logic fault;
  } scge_fault_state_t;

  scge_fault_state_t q;
  scge_fault_state_t d;

  // ==========================================================================
  // Check
  // ==========================================================================
  // A reserved position never has a unit behind it, so it always faults.
  always_comb begin
    d       = q;
    d.done  = access_req;
    d.fault = access_req &
              ~(clk_en[access_unit] &
                scge_pkg::SCGE_GATE_MASK[access_unit]);               // [RL2]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign access_done  = q.done;
  assign access_fault = q.fault;

endmodule

/* scge_ctrl.sv */
/*
  Clock gate enable control: run, sleep and deep-sleep gate registers, the
  run clock configuration with its automatic gating select, the choice of
  the applied enables and the fault answer for unclocked units.
  Assumes an AXI4-Lite master on aclk and power mode levels from the core.
*/
// What this block does
// [RL1] Each bit clock-enables one peripheral unit; here only the SCGE_GATE_MASK bits do, the rest are held at zero
// [RL2] Access to an unclocked unit gets fault
// [RL3] All gate bits reset to zero
// [RL4] Run, sleep, deep registers; mode picks one
// [RL5] Sleep registers apply only with automatic gating
// [RL6] Software enables needed units before use
// [RL7] Sleep register decodes at offset 0x114
// [RL8] Implemented bits per map, rest read zero
// [RL9] Unused positions stay reserved read-only zero
// [RL10] Software preserves reserved bits on updates
module scge_ctrl (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Power state of the processor
  input  wire logic        sleep_active,
  input  wire logic        deep_sleep_active,
  // Applied unit clock enables
  output logic [31:0]      unit_clk_en,
  // Peripheral access check
  input  wire logic        unit_access_req,
  input  wire logic [4:0]  unit_access_unit,
  output logic             unit_access_done,
  output logic             unit_access_fault
);

  typedef struct packed {
    logic [31:0]           run_gate;
    logic [31:0]           sleep_gate;
    logic [31:0]           deep_gate;
    logic [31:0]           run_cfg;
    logic [31:0]           clk_en;
    scge_pkg::scge_pmode_t mode;
    logic                  aw_held;
    logic [11:0]           aw_addr;
    logic                  w_held;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } scge_state_t;

  localparam scge_state_t SCGE_STATE_RESET = '{
    run_gate:   scge_pkg::SCGE_GATE_RESET,
    sleep_gate: scge_pkg::SCGE_GATE_RESET,
    deep_gate:  scge_pkg::SCGE_GATE_RESET,
    run_cfg:    scge_pkg::SCGE_CFG_RESET,
    clk_en:     scge_pkg::SCGE_GATE_RESET,
    mode:       scge_pkg::SCGE_PM_RUN,
    aw_addr:    12'h000,
    w_data:     32'h0000_0000,
    w_strb:     4'h0,
    bresp:      scge_pkg::SCGE_RESP_OKAY,
    rdata:      scge_pkg::SCGE_RDATA_NONE,
    rresp:      scge_pkg::SCGE_RESP_OKAY,
    default:    1'b0
  };

  scge_state_t q;
  scge_state_t d;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Byte-lane merge of a write into a register, then the writable mask.
  // Masking here keeps reserved bits at zero whatever software writes.
  function automatic logic [31:0] merge_word(
    input logic [31:0] old_val,
    input logic [31:0] wr_val,
    input logic [3:0]  strb,
    input logic [31:0] mask
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = wr_val[8*i +: 8];
      end
    end
    return res & mask;
  endfunction

  function automatic logic is_mapped(input logic [11:0] addr);
    logic [11:0] w;
    w = addr & scge_pkg::SCGE_WORD_MASK;
    return (w == scge_pkg::SCGE_OFS_RUN_CFG)   ||
           (w == scge_pkg::SCGE_OFS_RUN_GATE)  ||
           (w == scge_pkg::SCGE_OFS_SLEEP_GATE) ||
           (w == scge_pkg::SCGE_OFS_DEEP_GATE);
  endfunction

  // ==========================================================================
  // Next state
  // ==========================================================================
  logic        aw_take;
  logic        w_take;
  logic        aw_have;
  logic        w_have;
  logic        ar_take;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [11:0] rd_word;
  logic        auto_gate;

  always_comb begin
    d       = q;
    aw_take = s_axi_awvalid & q.awready;
    w_take  = s_axi_wvalid & q.wready;
    aw_have = q.aw_held | aw_take;
    w_have  = q.w_held | w_take;
    wr_addr = q.aw_held ? q.aw_addr : s_axi_awaddr;
    wr_data = q.w_held ? q.w_data : s_axi_wdata;
    wr_strb = q.w_held ? q.w_strb : s_axi_wstrb;
    ar_take = s_axi_arvalid & q.arready;
    rd_word = s_axi_araddr & scge_pkg::SCGE_WORD_MASK;

    // Write address and data are taken in either order and held.
    if (aw_take) begin
      d.aw_held = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      d.w_held = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    if (aw_have && w_have && !q.bvalid) begin
      d.aw_held = 1'b0;
      d.w_held  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = is_mapped(wr_addr) ? scge_pkg::SCGE_RESP_OKAY
                                     : scge_pkg::SCGE_RESP_SLVERR;
      unique case (wr_addr & scge_pkg::SCGE_WORD_MASK)
        scge_pkg::SCGE_OFS_RUN_CFG: begin
          d.run_cfg = merge_word(q.run_cfg, wr_data, wr_strb,
                                 scge_pkg::SCGE_CFG_MASK);
        end
        scge_pkg::SCGE_OFS_RUN_GATE: begin
          d.run_gate = merge_word(q.run_gate, wr_data, wr_strb,
                                  scge_pkg::SCGE_GATE_MASK);          // [RL8]
        end
        scge_pkg::SCGE_OFS_SLEEP_GATE: begin                          // [RL7]
          d.sleep_gate = merge_word(q.sleep_gate, wr_data, wr_strb,
                                    scge_pkg::SCGE_GATE_MASK);        // [RL9]
        end
        scge_pkg::SCGE_OFS_DEEP_GATE: begin
          d.deep_gate = merge_word(q.deep_gate, wr_data, wr_strb,
                                   scge_pkg::SCGE_GATE_MASK);
        end
        default: begin
        end
      endcase
    end

    // Reads answer one cycle after the address is taken.
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (ar_take) begin
      d.rvalid = 1'b1;
      d.rresp  = scge_pkg::SCGE_RESP_OKAY;
      unique case (rd_word)
        scge_pkg::SCGE_OFS_RUN_CFG:    d.rdata = q.run_cfg;
        scge_pkg::SCGE_OFS_RUN_GATE:   d.rdata = q.run_gate;
        scge_pkg::SCGE_OFS_SLEEP_GATE: d.rdata = q.sleep_gate;       // [RL7]
        scge_pkg::SCGE_OFS_DEEP_GATE:  d.rdata = q.deep_gate;
        default: begin
          d.rdata = scge_pkg::SCGE_RDATA_NONE;
          d.rresp = scge_pkg::SCGE_RESP_SLVERR;
        end
      endcase
    end

    d.awready = !d.aw_held && !d.bvalid;
    d.wready  = !d.w_held && !d.bvalid;
    d.arready = !d.rvalid;

    // Without automatic gating the run enables stay in force in sleep.
    // Deep sleep wins when both power levels are raised.
    auto_gate = q.run_cfg[scge_pkg::SCGE_BIT_AUTO_GATE];
    if (auto_gate && deep_sleep_active) begin                         // [RL5]
      d.mode = scge_pkg::SCGE_PM_DEEP;
    end else if (auto_gate && sleep_active) begin                     // [RL5]
      d.mode = scge_pkg::SCGE_PM_SLEEP;
    end else begin
      d.mode = scge_pkg::SCGE_PM_RUN;
    end

    unique case (d.mode)
      scge_pkg::SCGE_PM_RUN:   d.clk_en = d.run_gate;                 // [RL4]
      scge_pkg::SCGE_PM_SLEEP: d.clk_en = d.sleep_gate;               // [RL4]
      scge_pkg::SCGE_PM_DEEP:  d.clk_en = d.deep_gate;                // [RL4]
      default:                 d.clk_en = scge_pkg::SCGE_GATE_RESET;
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= SCGE_STATE_RESET;                                          // [RL3]
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Unit access check
  // ==========================================================================
  scge_fault u_fault (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .clk_en       (q.clk_en),
    .access_req   (unit_access_req),
    .access_unit  (unit_access_unit),
    .access_done  (unit_access_done),
    .access_fault (unit_access_fault)
  );

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // The enables leave straight from the state flops; a zero bit stops the
  // unit's clock at the gate cell outside this block.
  assign unit_clk_en   = q.clk_en;                                    // [RL1]
  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;

endmodule

/* scge_ctrl_checker.sv */
/*
  Concurrent checks for scge_ctrl, bound to every instance of it.
  Assumes one clock domain, aclk, with synchronous active-low aresetn.
*/
module scge_ctrl_checker (
  // Clock and reset
  input logic        aclk,
  input logic        aresetn,
  // Register bus handshakes
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  // Enables and access check
  input logic [31:0] unit_clk_en,
  input logic        unit_access_req,
  input logic [4:0]  unit_access_unit,
  input logic        unit_access_done,
  input logic        unit_access_fault
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // Bus sequences
  // ==========================================================================
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  sequence r_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence

  // ==========================================================================
  // Assertions
  // ==========================================================================
  AST_RST_CLEAR: assert property (
      $rose(aresetn) |-> unit_clk_en == 32'h0)
    else $error("enables not cleared by reset");
  AST_EN_MASK: assert property (
      (unit_clk_en & ~scge_pkg::SCGE_GATE_MASK) == 32'h0)
    else $error("reserved enable bit set");
  AST_WR_RESP: assert property (
      wr_take |=> s_axi_bvalid && !s_axi_awready)
    else $error("write not answered next cycle");
  AST_B_HOLD: assert property (
      b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RD_RESP: assert property (rd_take |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  AST_R_HOLD: assert property (
      r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_ACC_DONE: assert property (unit_access_req |=> unit_access_done)
    else $error("access not answered");
  AST_ACC_IDLE: assert property (
      !unit_access_req |=> !unit_access_done && !unit_access_fault)
    else $error("answer without access");
  AST_ACC_FAULT: assert property (
      unit_access_req |=>
        unit_access_fault == !$past(unit_clk_en[unit_access_unit]))
    else $error("fault disagrees with enable");
endmodule

bind scge_ctrl scge_ctrl_checker u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .unit_clk_en, .unit_access_req, .unit_access_unit,
  .unit_access_done, .unit_access_fault);

/* scge_ctrl_tb.sv */
/*
  Self-checking bench for scge_ctrl: register access, mode choice, faults.
  Assumes the checker is bound; every bus wait ends by handshake or timeout.
*/
module scge_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] GMASK = scge_pkg::SCGE_GATE_MASK;
  localparam logic [11:0] RUN = 12'h104, SLP = 12'h114, DEEP = 12'h124;
  localparam logic [11:0] CFG = 12'h060;
  localparam logic [1:0]  OK = 2'h0, ERR = 2'h2;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, sleep_active;
  logic        deep_sleep_active, unit_access_req, unit_access_done;
  logic        unit_access_fault;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, unit_clk_en;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [4:0]  unit_access_unit;
  int          fail_count = 0;
  int          n_tests = 0;

  scge_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sleep_active, .deep_sleep_active,
    .unit_clk_en, .unit_access_req, .unit_access_unit, .unit_access_done,
    .unit_access_fault);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  task end_of_test;
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Address and data are offered together and released as each is taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
      end
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        done = 1'b1;
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
      end
    end
  endtask

  task automatic en_is(input logic [31:0] e);
    repeat (3) @(posedge aclk);
    chk(unit_clk_en, e);
  endtask

  // Accesses go back to back; each answer is judged two edges later.
  task automatic sweep(input logic [31:0] e);
    for (int u = 0; u < 34; u++) begin
      @(posedge aclk);
      unit_access_req <= (u < 32);
      unit_access_unit <= 5'(u);
      if (u >= 2) begin
        chk({31'h0, unit_access_done}, 32'h1);
        chk({31'h0, unit_access_fault}, {31'h0, ~e[u-2]});
      end
    end
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task t_reset;
    chk(unit_clk_en, 32'h0);
    rd(RUN, 32'h0, OK);
    rd(SLP, 32'h0, OK);
    rd(DEEP, 32'h0, OK);
    rd(CFG, 32'h0, OK);
  endtask

  task t_map;
    wr(SLP, 32'hFFFF_FFFF, 4'hF, OK);
    rd(SLP, GMASK, OK);
    en_is(32'h0);
    wr(SLP, 32'h0, 4'h1, OK);
    rd(SLP, GMASK & 32'hFFFF_FF00, OK);
    rd(12'h116, GMASK & 32'hFFFF_FF00, OK);
    wr(SLP, (GMASK & 32'hFFFF_FF00) | 32'h1, 4'hF, OK);
    rd(SLP, GMASK & 32'hFFFF_FF01, OK);
    wr(12'h118, 32'hFFFF_FFFF, 4'hF, ERR);
    rd(12'h118, 32'h0, ERR);
  endtask

  // A write and a read run at once and the master holds off both response
  // readies, so the answers must stand until they are taken.
  task t_stall;
    logic aw_left, w_left, ar_left;
    aw_left = 1'b1;
    w_left = 1'b1;
    ar_left = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= DEEP;
    s_axi_wdata <= 32'h0000_0004;
    s_axi_wstrb <= 4'hF;
    s_axi_araddr <= SLP;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h7;
    while (aw_left || w_left || ar_left) begin
      @(posedge aclk);
      if (aw_left && s_axi_awready) begin
        aw_left = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_left && s_axi_wready) begin
        w_left = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (ar_left && s_axi_arready) begin
        ar_left = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end
    while (!(s_axi_bvalid && s_axi_rvalid)) @(posedge aclk);
    repeat (3) @(posedge aclk);
    chk({31'h0, s_axi_bvalid}, 32'h1);
    chk({31'h0, s_axi_rvalid}, 32'h1);
    s_axi_bready <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    chk({30'h0, s_axi_bresp}, {30'h0, OK});
    chk(s_axi_rdata, GMASK & 32'hFFFF_FF01);
    chk({30'h0, s_axi_rresp}, {30'h0, OK});
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    rd(DEEP, 32'h0000_0004, OK);
  endtask

  // Each mode register is loaded before the units are used.
  task t_mode;
    wr(RUN, 32'h1, 4'hF, OK);
    wr(SLP, GMASK, 4'hF, OK);
    wr(DEEP, 32'h10, 4'hF, OK);
    sleep_active <= 1'b1;
    en_is(32'h1);
    wr(CFG, 32'hFFFF_FFFF, 4'hF, OK);
    rd(CFG, 32'h0800_0000, OK);
    en_is(GMASK);
    sweep(GMASK);
    deep_sleep_active <= 1'b1;
    en_is(32'h10);
    sweep(32'h10);
    sleep_active <= 1'b0;
    deep_sleep_active <= 1'b0;
    en_is(32'h1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    en_is(32'h0);
    rd(SLP, 32'h0, OK);
  endtask

  initial begin
    #20000;
    fail_count++;
    end_of_test();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, sleep_active, deep_sleep_active} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 30'h0;
    {s_axi_wdata, s_axi_wstrb, unit_access_req, unit_access_unit} = 42'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_map();
    t_stall();
    t_mode();
    end_of_test();
  end
endmodule
